// ==== design/aost_core.sv ====
// offset trim, self-test actuation and corrected result registers
`timescale 1ns/1ns
`include "aost_regs.svh"
module aost_core
	import aost_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	output logic [7:0]       reg_rdata,
	input  wire logic        sample_valid,
	input  wire logic [15:0] raw_x,
	input  wire logic [15:0] raw_y,
	input  wire logic [15:0] raw_z,
	output logic             selftest_drive,
	output logic             low_power_sel,
	output logic [3:0]       rate_code,
	output logic             max_resolution_select,
	output logic [1:0]       range_code
);

	aost_state_t       st_q;
	aost_state_t       st_d;
	logic              rst_n;
	aost_scale_t       scale;
	logic [2:0][15:0]  raw;
	logic [2:0][15:0]  sum;

	// trim weight for a given format byte; also used by the checks below
	function automatic aost_scale_t scale_of(input logic [7:0] fmt);
		if (fmt[`AOST_FMT_MAXRES]) begin
			scale_of = AOST_SH_L2; // 3.9 mg counts
		end else begin
			case (fmt[`AOST_FMT_RANGE_HI:`AOST_FMT_RANGE_LO])
				2'h0:    scale_of = AOST_SH_L2;
				2'h1:    scale_of = AOST_SH_L1;
				2'h2:    scale_of = AOST_SH_0;
				default: scale_of = AOST_SH_R1;
			endcase
		end
	endfunction

	assign rst_n = st_q.rst[1];
	assign scale = scale_of(st_q.fmt); // constant 15.6 mg per count
	assign raw   = {raw_z, raw_y, raw_x};

	// one adder per axis
	generate
		for (genvar i = 0; i < 3; i++) begin : g_axis
			aost_axis_comp u_comp (
				.raw   (raw[i]),
				.trim  (st_q.ofs[i]),
				.scale (scale),
				.sum   (sum[i])
			);
		end
	endgenerate

	// next state: register writes, sample capture, read mux
	always_comb begin
		st_d = st_q;
		st_d.rst = {st_q.rst[0], 1'b1};
		if (reg_wr_en) begin
			if (reg_addr == `AOST_ADDR_OFS_X) begin
				st_d.ofs[0] = reg_wdata;
			end else if (reg_addr == `AOST_ADDR_OFS_Y) begin
				st_d.ofs[1] = reg_wdata;
			end else if (reg_addr == `AOST_ADDR_OFS_Z) begin
				st_d.ofs[2] = reg_wdata;
			end else if (reg_addr == `AOST_ADDR_RATE) begin
				st_d.rate = reg_wdata;
			end else if (reg_addr == `AOST_ADDR_FMT) begin
				st_d.fmt = reg_wdata;
			end
		end
		// results only move on a new sample so a read pair stays coherent
		if (sample_valid) begin
			st_d.res = sum;
		end
		if (reg_rd_en) begin
			if (reg_addr == `AOST_ADDR_OFS_X) begin
				st_d.rdata = st_q.ofs[0];
			end else if (reg_addr == `AOST_ADDR_OFS_Y) begin
				st_d.rdata = st_q.ofs[1];
			end else if (reg_addr == `AOST_ADDR_OFS_Z) begin
				st_d.rdata = st_q.ofs[2];
			end else if (reg_addr == `AOST_ADDR_RATE) begin
				st_d.rdata = st_q.rate;
			end else if (reg_addr == `AOST_ADDR_FMT) begin
				st_d.rdata = st_q.fmt;
			end else if (reg_addr >= `AOST_ADDR_RES_FIRST &&
					reg_addr <= `AOST_ADDR_RES_LAST) begin
				// low byte at the even address
				st_d.rdata = reg_addr[0] ?
					st_q.res[reg_addr[2:1] - 2'h1][15:8] :
					st_q.res[reg_addr[2:1] - 2'h1][7:0];
			end else begin
				st_d.rdata = `AOST_RD_UNMAPPED;
			end
		end
	end

	// async assert; the two-stage release lives in st_q.rst
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q.rst   <= 2'h0;
			st_q.ofs   <= {3{`AOST_RST_OFS}};
			st_q.rate  <= `AOST_RST_RATE;
			st_q.fmt   <= `AOST_RST_FMT;
			st_q.res   <= {3{`AOST_RST_RES}};
			st_q.rdata <= `AOST_RD_UNMAPPED;
		end else if (!rst_n) begin
			st_q     <= '0;
			st_q.rst <= st_d.rst;
			st_q.rate <= `AOST_RST_RATE;
		end else begin
			st_q <= st_d;
		end
	end

	// self-test force and sensor settings straight from the registers
	assign selftest_drive        = st_q.fmt[`AOST_FMT_SELFTEST];
	assign max_resolution_select = st_q.fmt[`AOST_FMT_MAXRES];
	assign range_code = st_q.fmt[`AOST_FMT_RANGE_HI:`AOST_FMT_RANGE_LO];
	assign low_power_sel         = st_q.rate[`AOST_RATE_LOWPWR];
	assign rate_code = st_q.rate[`AOST_RATE_CODE_HI:`AOST_RATE_CODE_LO];
	assign reg_rdata             = st_q.rdata;

	// checks
	property p_trim_reset;
		@(posedge core_clk) disable iff (!reset_n)
		$rose(rst_n) |-> st_q.ofs == {3{`AOST_RST_OFS}};
	endproperty
	a_trim_reset: assert property (p_trim_reset)
		else $error("trim not zero after reset");

	property p_trim_y_addr;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr_en && reg_addr == `AOST_ADDR_OFS_Y
		|=> st_q.ofs[1] == $past(reg_wdata) && $stable(st_q.ofs[0]);
	endproperty
	a_trim_y_addr: assert property (p_trim_y_addr)
		else $error("y trim write misplaced");

	property p_selftest_on;
		@(posedge core_clk) disable iff (!rst_n)
		reg_wr_en && reg_addr == `AOST_ADDR_FMT
		|=> selftest_drive == $past(reg_wdata[`AOST_FMT_SELFTEST]);
	endproperty
	a_selftest_on: assert property (p_selftest_on)
		else $error("self-test force does not follow format bit");

	property p_add_zero;
		@(posedge core_clk) disable iff (!rst_n)
		sample_valid && st_q.ofs[0] == 8'h00 |=> st_q.res[0] == $past(raw_x);
	endproperty
	a_add_zero: assert property (p_add_zero)
		else $error("zero trim changed x sample");

	property p_quarter;
		@(posedge core_clk) disable iff (!rst_n)
		sample_valid && st_q.fmt[`AOST_FMT_MAXRES] && raw_y == 16'h0000 &&
		st_q.ofs[1] == 8'hFF |=> st_q.res[1] == 16'hFFFC;
	endproperty
	a_quarter: assert property (p_quarter)
		else $error("max resolution trim not four counts");

	property p_fixed_8g;
		@(posedge core_clk) disable iff (!rst_n)
		sample_valid && st_q.fmt[3:0] == 4'h2 && raw_z == 16'h0000
		|=> st_q.res[2] == {{8{$past(st_q.ofs[2][7])}}, $past(st_q.ofs[2])};
	endproperty
	a_fixed_8g: assert property (p_fixed_8g)
		else $error("8 g trim weight wrong");

	property p_fixed_16g;
		@(posedge core_clk) disable iff (!rst_n)
		sample_valid && !reg_wr_en && st_q.fmt[3:0] == 4'h3 &&
		raw_x == 16'h0000 && st_q.ofs[0] == 8'h02
		##1 (!reg_wr_en && !sample_valid) [*2]
		|-> st_q.res[0] == 16'h0001 && scale == AOST_SH_R1;
	endproperty
	a_fixed_16g: assert property (p_fixed_16g)
		else $error("16 g trim not halved");

	property p_read_result;
		@(posedge core_clk) disable iff (!rst_n)
		reg_rd_en && reg_addr == `AOST_ADDR_RES_LAST
		|=> reg_rdata == $past(st_q.res[2][15:8]);
	endproperty
	a_read_result: assert property (p_read_result)
		else $error("z high byte read wrong");

endmodule

// ==== design/aost_regs.svh ====
// register offsets, field positions and reset values of the offset block
`ifndef AOST_REGS_SVH
`define AOST_REGS_SVH

`define AOST_ADDR_OFS_X     8'h1E
`define AOST_ADDR_OFS_Y     8'h1F
`define AOST_ADDR_OFS_Z     8'h20
`define AOST_ADDR_RATE      8'h2C
`define AOST_ADDR_FMT       8'h31
`define AOST_ADDR_RES_FIRST 8'h32
`define AOST_ADDR_RES_LAST  8'h37

`define AOST_RST_OFS        8'h00
`define AOST_RST_RATE       8'h0A
`define AOST_RST_FMT        8'h00
`define AOST_RST_RES        16'h0000
`define AOST_RD_UNMAPPED    8'h00

`define AOST_FMT_SELFTEST   7
`define AOST_FMT_MAXRES     3
`define AOST_FMT_RANGE_HI   1
`define AOST_FMT_RANGE_LO   0
`define AOST_RATE_LOWPWR    4
`define AOST_RATE_CODE_HI   3
`define AOST_RATE_CODE_LO   0

`endif

// ==== design/aost_pkg.sv ====
// types shared by the offset and self-test block
package aost_pkg;

	typedef logic [7:0]  aost_byte_t;
	typedef logic [15:0] aost_word_t;

	// offset weight relative to one output count
	typedef enum logic [1:0] {
		AOST_SH_L2,
		AOST_SH_L1,
		AOST_SH_0,
		AOST_SH_R1
	} aost_scale_t;

	typedef struct packed {
		logic [1:0]            rst;
		aost_byte_t [2:0]      ofs;
		aost_byte_t            rate;
		aost_byte_t            fmt;
		aost_word_t [2:0]      res;
		aost_byte_t            rdata;
	} aost_state_t;

endpackage

// ==== design/aost_axis_comp.sv ====
// one axis: scale the trim value and add it to a sample, with saturation
`timescale 1ns/1ns
module aost_axis_comp
	import aost_pkg::*;
(
	input  wire logic [15:0] raw,
	input  wire logic [7:0]  trim,
	input  wire aost_scale_t scale,
	output logic [15:0]      sum
);

	logic signed [17:0] trim_ext;
	logic signed [17:0] total;

	// sign-extend, then bring the trim to output count weight
	always_comb begin
		trim_ext = {{10{trim[7]}}, trim};
		case (scale)
			AOST_SH_L2: trim_ext = trim_ext <<< 2;
			AOST_SH_L1: trim_ext = trim_ext <<< 1;
			AOST_SH_0:  trim_ext = trim_ext;
			default:    trim_ext = trim_ext >>> 1;
		endcase
		total = {{2{raw[15]}}, raw} + trim_ext;
		// clamp instead of wrapping so a large trim cannot flip the sign
		if (total > 18'sh07FFF) begin
			sum = 16'h7FFF;
		end else if (total < -18'sh08000) begin
			sum = 16'h8000;
		end else begin
			sum = total[15:0];
		end
	end

endmodule

// ==== sim/aost_host.sv ====
// host model: register strobes and the self-test set-up sequence
`timescale 1ns/1ns
module aost_host (
	input  wire logic       core_clk,
	input  wire logic [7:0] reg_rdata,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr_en,
	output logic            reg_rd_en
);
	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
	end

	// one-cycle write strobe, changed only just after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~d; // stale data must not look valid
	endtask

	// read data is registered; take it at the edge after the strobe edge,
	// where it stands settled and no new read can move it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask

	// 100 Hz, normal power, 16 g at max resolution, then force on
	task automatic selftest_on();
		wr(8'h2C, 8'h0A);
		wr(8'h31, 8'h0B);
		wr(8'h31, 8'h8B);
	endtask
endmodule

// ==== sim/tb.sv ====
// bench: drives the offset block, models corrected results, checks reads
`timescale 1ns/1ns
module tb;
	import aost_pkg::*;
	logic        core_clk, reset_n, sample_valid, selftest_drive;
	logic        low_power_sel, max_resolution_select, reg_wr_en, reg_rd_en;
	logic [1:0]  range_code;
	logic [3:0]  rate_code;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, b, h, fmt;
	logic [15:0] raw [3];
	logic [7:0]  trim [3];
	logic [7:0]  ra [8] = '{8'h1E, 8'h1F, 8'h20, 8'h2C, 8'h31, 8'h32, 8'h33,
		8'h3A};
	logic [7:0]  fl [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08};
	integer      failures = 0, comparisons = 0, seed = 14617, i, k;

	aost_core uut (.core_clk(core_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
		.sample_valid(sample_valid), .raw_x(raw[0]), .raw_y(raw[1]),
		.raw_z(raw[2]), .selftest_drive(selftest_drive),
		.low_power_sel(low_power_sel), .rate_code(rate_code),
		.max_resolution_select(max_resolution_select),
		.range_code(range_code));
	aost_host host (.core_clk(core_clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en));

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic results();
		if (failures == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// scaled trim plus sample, clamped to the 16-bit signed span
	function automatic logic [15:0] model(input logic [15:0] r,
		input logic [7:0] t);
		integer s;
		s = $signed(t);
		if (fmt[3] || fmt[1:0] == 2'd0) s = s * 4;
		else if (fmt[1:0] == 2'd1) s = s * 2;
		else if (fmt[1:0] == 2'd3) s = s >>> 1;
		s = s + $signed(r);
		if (s > 32767) s = 32767;
		if (s < -32768) s = -32768;
		return s[15:0];
	endfunction

	// one sample pulse; kind 1 puts x and z at the top end and y at the bottom end, kind 2 is
	// a zero input so the scaled trim shows alone
	task automatic sample(input bit check, input logic [1:0] kind);
		@(posedge core_clk);
		for (k = 0; k < 3; k++) begin
			if (kind == 2'd1) begin
				raw[k] <= k[0] ? 16'h8000 : 16'h7FFF;
			end else if (kind == 2'd2) begin
				raw[k] <= 16'h0000;
			end else begin
				raw[k] <= 16'($random(seed));
			end
		end
		sample_valid <= 1'b1;
		@(posedge core_clk);
		sample_valid <= 1'b0;
		for (k = 0; k < 3 && check; k++) begin
			host.rd(8'(8'h32 + 2 * k), b);
			host.rd(8'(8'h33 + 2 * k), h);
			chk({h, b}, model(raw[k], trim[k]));
		end
		chk({selftest_drive, max_resolution_select, range_code},
			{fmt[7], fmt[3], fmt[1:0]});
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// hang guard, far beyond the roughly 860 cycles the run needs
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		results();
	end

	initial begin
		reset_n = 1'b0;
		sample_valid = 1'b0;
		raw = '{3{16'h0000}};
		trim = '{3{8'h00}};
		fmt = 8'h00;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		// result bytes refuse writes; power-up values and a hole read back
		host.wr(8'h33, 8'hFF);
		for (i = 0; i < 8; i++) begin
			host.rd(ra[i], b);
			chk(b, i == 3 ? 8'h0A : 8'h00);
		end
		// untouched trims pass the samples through unchanged
		sample(1'b1, 2'd0);
		// a rate write lands in the register and on the setting pins
		host.wr(8'h2C, 8'h17);
		host.rd(8'h2C, b);
		chk(b, 8'h17);
		chk({low_power_sel, rate_code}, 5'h17);
		for (i = 0; i < 3; i++) begin
			trim[i] = 8'($random(seed));
			host.wr(8'(8'h1E + i), trim[i]);
		end
		for (i = 0; i < 3; i++) begin
			host.rd(8'(8'h1E + i), b);
			chk(b, trim[i]);
		end
		// every range without max resolution, then max resolution at range 0
		for (i = 0; i < 5; i++) begin
			fmt = fl[i];
			host.wr(8'h31, fmt);
			sample(1'b1, 2'd0);
			sample(1'b1, 2'd1);
		end
		// fixed trims on a zero input expose the weight of one count
		trim[0] = 8'h02;
		trim[1] = 8'hFF;
		host.wr(8'h1E, trim[0]);
		host.wr(8'h1F, trim[1]);
		for (i = 0; i < 5; i++) begin
			fmt = fl[i];
			host.wr(8'h31, fmt);
			sample(1'b1, 2'd2);
		end
		// reference set with the force off, in normal power
		host.wr(8'h2C, 8'h0A);
		fmt = 8'h0B;
		host.wr(8'h31, fmt);
		repeat (10) sample(1'b1, 2'd0);
		host.selftest_on();
		fmt = 8'h8B;
		repeat (4) sample(1'b0, 2'd0);
		repeat (10) sample(1'b1, 2'd0);
		chk({low_power_sel, rate_code}, 5'h0A);
		host.wr(8'h31, 8'h0B);
		fmt = 8'h0B;
		sample(1'b1, 2'd1);
		// a second power-up must drop trims; the self-test force, already off, must stay off
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 3; i++) begin
			host.rd(8'(8'h1E + i), b);
			chk(b, 8'h00);
		end
		chk({selftest_drive, low_power_sel, rate_code}, 6'h0A);
		results();
	end
endmodule
